// [design/apci_defines.vh]
/*
 * Shared constants of the adapter port command interface: register
 * indices, flag bit positions, command codes, bus timing.
 * Assumes inclusion, by bare name, by the design files that use its constants.
 */
`ifndef APCI_DEFINES_VH
`define APCI_DEFINES_VH

// Register word indices within the host I/O page window
`define APCI_IDX_CMD 2'h0
`define APCI_IDX_STATE 2'h1
`define APCI_IDX_ADLO 2'h2
`define APCI_IDX_ADHI 2'h3

// Flag bits of port_command_and_flags
`define APCI_B_STATUS_ERROR_FLAG 15
`define APCI_B_COMMAND_ERROR_FLAG 14
`define APCI_B_RXI 13
`define APCI_B_TXI 12
`define APCI_B_DNI 11
`define APCI_B_RCBI 10
`define APCI_B_USCI 8
`define APCI_B_SUM 7
`define APCI_B_INTERRUPT_ENABLE_BIT 6
`define APCI_B_DEVICE_RESET_BIT 5
`define APCI_CMD_MSB 3
// Flag values after any reset: only the done flag stands
`define APCI_FLAG_INIT 8'h08

// Port command codes
`define APCI_CMD_NOOP 4'h0
`define APCI_CMD_LDADDR 4'h1
`define APCI_CMD_GETCMD 4'h2

// Bus addressing
`define APCI_CSR_BASE 18'h3FF00
`define APCI_ADLO_OFS 18'h00004
`define APCI_BLK_WORDS 2'h3
`define APCI_ADDR_WORDS 2'h1

// Last wait cycle before a read is abandoned
`define APCI_TMO_LAST 9'h0F9

`endif

// [design/apci_flag.v]
/*
 * One sticky attention flag: hardware sets, driver clears by writing one.
 * Assumes set and clear are single-cycle strobes on core_clk.
 */
`timescale 1ns/1ns
module apci_flag
#(
    parameter INIT = 1'b0
)
(
    input wire core_clk,
    input wire rst_b,
    input wire set,
    input wire clr,
    output reg flag_reg
);

    // Set wins over a clear in the same cycle so no event is lost
    always @(posedge core_clk)
    begin
        if (!rst_b)
            flag_reg <= INIT;
        else if (set)
            flag_reg <= 1'b1;
        else if (clr)
            flag_reg <= 1'b0;
    end

endmodule

// [design/apci_dma.v]
/*
 * Single-word bus master read with timeout.
 * Assumes the bus answers with a one-cycle acknowledge carrying data,
 * synchronous to core_clk.
 */
`timescale 1ns/1ns
`include "apci_defines.vh"
module apci_dma
(
    input wire core_clk,
    input wire rst_b,
    input wire start,
    input wire [17:0] addr,
    output reg dma_req,
    output reg [17:0] dma_addr,
    input wire dma_ack,
    input wire [15:0] dma_rdata,
    output reg [15:0] word_reg,
    output reg done_reg,
    output reg tmo_reg
);

    localparam [8:0] TMO_LAST = `APCI_TMO_LAST;

    reg [8:0] wait_reg; // Cycles spent waiting for the answer

    // Request stays up until answered or timed out
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            dma_req <= 1'b0;
            dma_addr <= 18'h00000;
            word_reg <= 16'h0000;
            done_reg <= 1'b0;
            tmo_reg <= 1'b0;
            wait_reg <= 9'h000;
        end
        else
        begin
            done_reg <= 1'b0;
            tmo_reg <= 1'b0;
            if (!dma_req)
            begin
                // Idle: new read accepted
                if (start)
                begin
                    dma_req <= 1'b1;
                    dma_addr <= {addr[17:1], 1'b0};
                    wait_reg <= 9'h000;
                end
            end
            else if (dma_ack)
            begin
                // Answer arrived
                dma_req <= 1'b0;
                word_reg <= dma_rdata;
                done_reg <= 1'b1;
            end
            else if (wait_reg == TMO_LAST)
            begin
                // No slave answered; give up rather than hang the port
                dma_req <= 1'b0;
                tmo_reg <= 1'b1;
            end
            else
                wait_reg <= wait_reg + 9'h001;
        end
    end

endmodule

// [design/apci_top.v]
/*
 * Port command interface of a network adapter: four control/status
 * registers on the host bus, command interpreter, block fetch by DMA.
 * Assumes the host bus slave and master sides are synchronous to
 * core_clk; ring and status events come from same-clock logic.
 */
// Functional notes
// RQ1 - Command code in low bits, then done or error; no-op code 0000 sets neither
// RQ2 - Command block is four 16-bit words
// RQ3 - Ancillary commands travel through host memory block
// RQ4 - Driver loads block address before fetch
// RQ5 - Get-command reads block by DMA, executes
// RQ6 - Completion interrupts: done or error flag
// RQ7 - Four registers, word and byte access
// RQ8 - Device reads address registers across host bus
// RQ9 - Status error sets bit 15, driver clears
// RQ10 - Function error or timeout sets bit 14
// RQ11 - Received message sets bit 13
// RQ12 - Transmit suspend/done/error sets bit 12
// RQ13 - Completion sets done bit 11, interrupts
// RQ14 - Transmit and receive rings live in memory
// RQ15 - Auxiliary block format depends on function
// RQ16 - Codes 0001 load address, 0010 execute
// RQ17 - Summary bit 7 is OR of 15:8
// RQ18 - Only driver changes interrupt enable bit 6
// RQ19 - Bit 5 resets; done, summary read one
// RQ20 - Write one clears a flag
// RQ21 - Interrupt while summary and enable set
`timescale 1ns/1ns
`include "apci_defines.vh"
module apci_top
(
    input wire core_clk,
    input wire rst_b,
    input wire csr_sel,
    input wire [1:0] csr_idx,
    input wire csr_wr,
    input wire [1:0] csr_be,
    input wire [15:0] csr_wdata,
    output reg [15:0] csr_rdata,
    output wire dma_req,
    output wire [17:0] dma_addr,
    input wire dma_ack,
    input wire [15:0] dma_rdata,
    output reg func_valid,
    output reg [7:0] func_code,
    output reg [15:0] func_arg1,
    output reg [15:0] func_arg2,
    output reg [15:0] func_arg3,
    input wire func_done,
    input wire func_fail,
    input wire status_err_evt,
    input wire rx_msg_evt,
    input wire tx_ring_evt,
    input wire rx_nobuf_evt,
    input wire state_chg_evt,
    output wire host_irq
);

    // One-hot command states
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_ADDR = 5'h02;
    localparam [4:0] S_FETCH = 5'h04;
    localparam [4:0] S_EXEC = 5'h08;
    localparam [4:0] S_FIN = 5'h10;

    reg [4:0] state_reg; // Interpreter state
    reg [4:0] state_next;
    reg soft_rst_reg; // Reset strobe from bit 5 write
    reg interrupt_enable_bit_reg; // Interrupt enable, driver-owned
    reg [3:0] cmd_reg; // Last port command accepted
    reg errtype_reg; // 1: bus timeout, 0: function error
    reg [15:0] adlo_reg; // Block address low, host-written
    reg [15:0] adhi_reg; // Block address high, host-written
    reg [17:0] blk_addr_reg; // Internal copy of block address
    reg [1:0] wcnt_reg; // Word index of the current fetch
    reg start_reg; // Kick to the DMA engine
    reg ok_reg; // Command finished well
    reg err_reg; // Command finished badly
    reg fn_err_reg; // Error cause to latch
    reg tmo_seen_reg; // Timeout seen in this command
    reg [17:0] rd_addr; // Address of next master read
    wire [15:0] dma_word; // Word returned by the master
    wire dma_done; // Master read answered
    wire dma_tmo; // Master read timed out
    wire rst_int_b; // Hard or soft reset, active low
    wire wr0; // Write to command register
    wire [7:0] flags; // Flags 15:8
    wire [7:0] flag_set; // Set strobes for flags
    wire [7:0] flag_clr; // Clear strobes for flags
    wire summary; // Interrupt summary
    wire cmd_go; // Port command accepted

    // Soft reset returns every block to power-up state [RQ19]
    assign rst_int_b = rst_b & ~soft_rst_reg;

    assign wr0 = csr_sel & csr_wr & (csr_idx == `APCI_IDX_CMD);

    // Command written in the low byte starts only when idle
    assign cmd_go = wr0 & csr_be[0] & state_reg[0]
                    & ~csr_wdata[`APCI_B_DEVICE_RESET_BIT]; // [RQ1]

    // Flag set sources, bit 9 has no source and reads zero
    assign flag_set = {status_err_evt, // [RQ9]
                       err_reg, // [RQ10]
                       rx_msg_evt, // [RQ11] [RQ14]
                       tx_ring_evt, // [RQ12]
                       ok_reg, // [RQ13]
                       rx_nobuf_evt,
                       1'b0,
                       state_chg_evt};

    // High-byte write of ones clears the matching flags [RQ20]
    assign flag_clr = (wr0 & csr_be[1]) ? csr_wdata[15:8] : 8'h00;

    // One sticky flag per attention bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_flag
            apci_flag
            #(
                .INIT(((`APCI_FLAG_INIT >> gi) & 1) != 0)
            )
            u_flag
            (
                .core_clk(core_clk),
                .rst_b(rst_int_b),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .flag_reg(flags[gi])
            );
        end
    endgenerate

    // Summary of all attention flags [RQ17]
    assign summary = |flags;

    // Interrupt line follows summary gated by enable [RQ6] [RQ21]
    assign host_irq = summary & interrupt_enable_bit_reg;

    // Single-word master used for both address and block reads
    apci_dma u_dma
    (
        .core_clk(core_clk),
        .rst_b(rst_int_b),
        .start(start_reg),
        .addr(rd_addr),
        .dma_req(dma_req),
        .dma_addr(dma_addr),
        .dma_ack(dma_ack),
        .dma_rdata(dma_rdata),
        .word_reg(dma_word),
        .done_reg(dma_done),
        .tmo_reg(dma_tmo)
    );

    // Next read address: own address registers or the block
    always @*
    begin
        if (state_reg[1])
            rd_addr = `APCI_CSR_BASE + `APCI_ADLO_OFS
                      + {15'h0000, wcnt_reg, 1'b0}; // [RQ8]
        else
            rd_addr = blk_addr_reg
                      + {15'h0000, wcnt_reg, 1'b0}; // [RQ2]
    end

    // Control register writes; bit 5 is write-only
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            soft_rst_reg <= 1'b0;
            interrupt_enable_bit_reg <= 1'b0;
            cmd_reg <= `APCI_CMD_NOOP;
        end
        else
        begin
            soft_rst_reg <= wr0 & csr_be[0]
                            & csr_wdata[`APCI_B_DEVICE_RESET_BIT]; // [RQ19]
            if (soft_rst_reg)
            begin
                interrupt_enable_bit_reg <= 1'b0;
                cmd_reg <= `APCI_CMD_NOOP;
            end
            else if (wr0 & csr_be[0])
            begin
                // Only the driver touches enable [RQ18]
                interrupt_enable_bit_reg <= csr_wdata[`APCI_B_INTERRUPT_ENABLE_BIT];
                if (cmd_go)
                    cmd_reg <= csr_wdata[`APCI_CMD_MSB:0];
            end
        end
    end

    // Address registers, word or byte writable [RQ7]
    always @(posedge core_clk)
    begin
        if (!rst_int_b)
        begin
            adlo_reg <= 16'h0000;
            adhi_reg <= 16'h0000;
        end
        else if (csr_sel & csr_wr)
        begin
            // Driver stores the block address here first [RQ4]
            if (csr_idx == `APCI_IDX_ADLO)
            begin
                if (csr_be[0])
                    adlo_reg[7:0] <= csr_wdata[7:0];
                if (csr_be[1])
                    adlo_reg[15:8] <= csr_wdata[15:8];
            end
            else if (csr_idx == `APCI_IDX_ADHI)
            begin
                if (csr_be[0])
                    adhi_reg[7:0] <= csr_wdata[7:0];
                if (csr_be[1])
                    adhi_reg[15:8] <= csr_wdata[15:8];
            end
        end
    end

    // Interpreter state transitions
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                // No-op and unknown codes finish at once
                if (cmd_go)
                begin
                    if (csr_wdata[3:0] == `APCI_CMD_LDADDR)
                        state_next = S_ADDR; // [RQ16]
                    else if (csr_wdata[3:0] == `APCI_CMD_GETCMD)
                        state_next = S_FETCH; // [RQ16]
                end
            end
            S_ADDR:
            begin
                if (dma_tmo)
                    state_next = S_FIN;
                else if (dma_done & (wcnt_reg == `APCI_ADDR_WORDS))
                    state_next = S_FIN;
            end
            S_FETCH:
            begin
                if (dma_tmo)
                    state_next = S_FIN;
                else if (dma_done & (wcnt_reg == `APCI_BLK_WORDS))
                    state_next = S_EXEC;
            end
            S_EXEC:
            begin
                if (func_done | func_fail)
                    state_next = S_FIN;
            end
            S_FIN:
                state_next = S_IDLE;
            default:
                state_next = S_IDLE;
        endcase
    end

    // Interpreter datapath and completion strobes
    always @(posedge core_clk)
    begin
        if (!rst_int_b)
        begin
            state_reg <= S_IDLE;
            wcnt_reg <= 2'h0;
            start_reg <= 1'b0;
            blk_addr_reg <= 18'h00000;
            ok_reg <= 1'b0;
            err_reg <= 1'b0;
            fn_err_reg <= 1'b0;
            errtype_reg <= 1'b0;
            func_valid <= 1'b0;
            func_code <= 8'h00;
            func_arg1 <= 16'h0000;
            func_arg2 <= 16'h0000;
            func_arg3 <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            start_reg <= 1'b0;
            ok_reg <= 1'b0;
            err_reg <= 1'b0;
            func_valid <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    wcnt_reg <= 2'h0;
                    fn_err_reg <= 1'b0;
                    start_reg <= state_next[1] | state_next[2];
                end
                S_ADDR:
                begin
                    // Keep an internal copy of the address [RQ8]
                    if (dma_tmo)
                        fn_err_reg <= 1'b1;
                    else if (dma_done)
                    begin
                        if (wcnt_reg == 2'h0)
                            blk_addr_reg[15:0] <= dma_word;
                        else
                            blk_addr_reg[17:16] <= dma_word[1:0];
                        wcnt_reg <= wcnt_reg + 2'h1;
                        start_reg <= ~state_next[4];
                    end
                end
                S_FETCH:
                begin
                    // Four block words by DMA, code in low byte [RQ5]
                    if (dma_tmo)
                        fn_err_reg <= 1'b1;
                    else if (dma_done)
                    begin
                        case (wcnt_reg)
                            2'h0: func_code <= dma_word[7:0]; // [RQ2]
                            2'h1: func_arg1 <= dma_word;
                            2'h2: func_arg2 <= dma_word;
                            default: func_arg3 <= dma_word;
                        endcase
                        wcnt_reg <= wcnt_reg + 2'h1;
                        start_reg <= ~state_next[3];
                        func_valid <= state_next[3]; // [RQ3] [RQ15]
                    end
                end
                S_EXEC:
                begin
                    // Function logic reports its outcome
                    if (func_fail)
                        fn_err_reg <= 1'b1;
                end
                S_FIN:
                begin
                    // Done or error, then interrupt [RQ6]
                    ok_reg <= ~fn_err_reg & ~dma_tmo; // [RQ13]
                    err_reg <= fn_err_reg | dma_tmo; // [RQ10]
                    if (fn_err_reg | dma_tmo)
                        errtype_reg <= tmo_seen_reg;
                end
                default:
                    wcnt_reg <= 2'h0;
            endcase
            // Idle no-op gives no done; other unknown codes complete
            if (cmd_go & ~state_next[1] & ~state_next[2]
                & (csr_wdata[3:0] != `APCI_CMD_NOOP))
                ok_reg <= 1'b1; // [RQ1]
        end
    end

    // Timeout cause tracked across the command
    always @(posedge core_clk)
    begin
        if (!rst_int_b)
            tmo_seen_reg <= 1'b0;
        else if (state_reg[0])
            tmo_seen_reg <= 1'b0;
        else if (dma_tmo)
            tmo_seen_reg <= 1'b1; // [RQ10]
    end

    // Registered read mux; unused bits read zero [RQ7]
    always @(posedge core_clk)
    begin
        if (!rst_int_b)
            csr_rdata <= 16'h0000;
        else if (csr_sel & ~csr_wr)
        begin
            case (csr_idx)
                `APCI_IDX_CMD:
                    csr_rdata <= {flags, summary, interrupt_enable_bit_reg,
                                  2'b00, cmd_reg};
                `APCI_IDX_STATE:
                    csr_rdata <= {8'h00, errtype_reg, 2'b00,
                                  state_reg};
                `APCI_IDX_ADLO:
                    csr_rdata <= adlo_reg;
                default:
                    csr_rdata <= adhi_reg;
            endcase
        end
    end

endmodule

// [tb/apci_host_model.sv]
/*
 * Host side of the master bus: four block words and the host's view of
 * the block address registers. Assumes one read at a time on core_clk.
 */
`timescale 1ns/1ns
`include "apci_defines.vh"
module apci_host_model
(
    input wire core_clk,
    input wire rst_b,
    input wire dma_req,
    input wire [17:0] dma_addr,
    output reg dma_ack,
    output reg [15:0] dma_rdata,
    input wire [3:0] delay,
    input wire mute,
    input wire [15:0] adlo,
    input wire [15:0] adhi,
    input wire mem_we,
    input wire [1:0] mem_idx,
    input wire [15:0] mem_wdata
);
    reg [15:0] mem [0:3]; // Block of four words, 8-byte aligned
    reg [3:0] wait_cnt; // Cycles the current read has waited

    // Driver fills the block in memory, not in the device
    always @(posedge core_clk)
    begin
        if (mem_we)
            mem[mem_idx] <= mem_wdata;
    end

    // One-cycle answer after a set wait; mute forces a bus timeout
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            dma_ack <= 1'b0;
            wait_cnt <= 4'h0;
            dma_rdata <= 16'h0000;
        end
        else if (dma_req && !dma_ack && !mute && wait_cnt >= delay)
        begin
            dma_ack <= 1'b1;
            wait_cnt <= 4'h0;
            // Device's own address registers read across the bus
            if (dma_addr == `APCI_CSR_BASE + `APCI_ADLO_OFS)
                dma_rdata <= adlo;
            else if (dma_addr == `APCI_CSR_BASE + 18'h00006)
                dma_rdata <= adhi;
            else
                dma_rdata <= mem[dma_addr[2:1]];
        end
        else
        begin
            // Released data toggles so a stale word never matches
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_req && !dma_ack)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// [tb/apci_top_sva.sv]
/*
 * Port assertions of the command interface.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module apci_top_sva
(
    input wire core_clk,
    input wire rst_b,
    input wire csr_sel,
    input wire [1:0] csr_idx,
    input wire csr_wr,
    input wire [15:0] csr_rdata,
    input wire dma_req,
    input wire [17:0] dma_addr,
    input wire dma_ack,
    input wire func_valid,
    input wire host_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Reads of the flag word and the state word
    wire rd0 = csr_sel && !csr_wr && csr_idx == 2'h0;
    wire rd1 = csr_sel && !csr_wr && csr_idx == 2'h1;

    a_summary_or: assert property (rd0 |=>
        csr_rdata[7] == (|csr_rdata[15:8])) else $error("summary bad");
    a_irq_gate: assert property (rd0 |=>
        $past(host_irq) == (csr_rdata[7] && csr_rdata[6]))
        else $error("irq level bad");
    a_zero_bits: assert property (rd0 |=>
        !csr_rdata[9] && csr_rdata[5:4] == 2'h0) else $error("zero bits");
    a_state_zero: assert property (rd1 |=>
        csr_rdata[15:8] == 8'h00 && csr_rdata[6:5] == 2'h0)
        else $error("state word reserved bits");
    a_dma_even: assert property (dma_req |-> !dma_addr[0])
        else $error("odd master address");
    a_dma_hold: assert property (dma_req && !dma_ack ##1 dma_req
        |-> $stable(dma_addr)) else $error("address moved");
    a_ack_release: assert property (dma_ack && dma_req |=> !dma_req)
        else $error("request kept after ack");
    a_dma_bound: assert property ($rose(dma_req) |->
        ##[1:260] !dma_req) else $error("read never ends");
    a_valid_pulse: assert property (func_valid |=> !func_valid)
        else $error("function strobe too long");
    a_reset_quiet: assert property ($rose(rst_b) |->
        !host_irq && !dma_req && !func_valid) else $error("reset outputs");

    // Main scenarios reached
    cover property (func_valid);
    cover property (rd0 ##1 csr_rdata[14]);
    cover property ($rose(host_irq));
endmodule

bind apci_top apci_top_sva apci_top_sva_inst (.core_clk(core_clk),
    .rst_b(rst_b), .csr_sel(csr_sel), .csr_idx(csr_idx), .csr_wr(csr_wr),
    .csr_rdata(csr_rdata), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_ack(dma_ack), .func_valid(func_valid), .host_irq(host_irq));

// [tb/apci_top_tb.sv]
/*
 * Self-checking bench of the command interface with a host model.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
    error_cnt++; $display("Error %s exp %h got %h", nm, ex, gt); end end
module apci_top_tb;
    logic core_clk, rst_b, csr_sel, csr_wr, dma_ack, host_irq, func_valid;
    logic func_done, func_fail, mute, mem_we, want_fail, dma_req;
    logic [1:0] csr_idx, csr_be, mem_idx;
    logic [3:0] delay;
    logic [4:0] evt; // Ring and status event pulses
    logic [15:0] csr_wdata, csr_rdata, dma_rdata, mem_wdata, v, e, ex;
    logic [15:0] words [4];
    logic [15:0] flag_tab [5] = '{16'h8000, 16'h2000, 16'h1000, 16'h0400,
        16'h0100};
    logic [17:0] blk, dma_addr;
    logic [7:0] cap_code, func_code;
    logic [15:0] a1, a2, a3;
    logic [47:0] cap_args;
    int k, i, checked, error_cnt;
    int unsigned seed_val;

    apci_top apci_top_inst (.core_clk(core_clk), .rst_b(rst_b),
        .csr_sel(csr_sel), .csr_idx(csr_idx), .csr_wr(csr_wr),
        .csr_be(csr_be), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
        .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack),
        .dma_rdata(dma_rdata), .func_valid(func_valid),
        .func_code(func_code), .func_arg1(a1), .func_arg2(a2),
        .func_arg3(a3), .func_done(func_done), .func_fail(func_fail),
        .status_err_evt(evt[0]), .rx_msg_evt(evt[1]), .tx_ring_evt(evt[2]),
        .rx_nobuf_evt(evt[3]), .state_chg_evt(evt[4]), .host_irq(host_irq));
    apci_host_model apci_host_model_inst (.core_clk(core_clk),
        .rst_b(rst_b), .dma_req(dma_req), .dma_addr(dma_addr),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .delay(delay),
        .mute(mute), .adlo(blk[15:0]), .adhi({14'h0000, blk[17:16]}),
        .mem_we(mem_we), .mem_idx(mem_idx), .mem_wdata(mem_wdata));

    // 25 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Function runner answers one cycle after the strobe
    always @(posedge core_clk)
    begin
        func_done <= 1'b0;
        func_fail <= 1'b0;
        if (func_valid === 1'b1)
        begin
            cap_code <= func_code;
            cap_args <= {a1, a2, a3};
            func_done <= !want_fail;
            func_fail <= want_fail;
        end
    end

    // Byte-lane merge of a register write
    function automatic [15:0] merge(input [15:0] o, n, input [1:0] be);
        merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction

    task automatic finish_test();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic csr_w(input [1:0] idx, input [1:0] be, input [15:0] d);
        @(posedge core_clk);
        csr_sel <= 1'b1;
        csr_wr <= 1'b1;
        csr_idx <= idx;
        csr_be <= be;
        csr_wdata <= d;
        @(posedge core_clk);
        csr_sel <= 1'b0;
        csr_wr <= 1'b0;
    endtask

    // Read data is registered at the taking edge
    task automatic csr_r(input [1:0] idx, output logic [15:0] d);
        @(posedge core_clk);
        csr_sel <= 1'b1;
        csr_idx <= idx;
        @(posedge core_clk);
        csr_sel <= 1'b0;
        #1 d = csr_rdata;
    endtask

    task automatic chk_rd(input [1:0] idx, input [15:0] ex, input string nm);
        logic [15:0] d;
        csr_r(idx, d);
        `CHK(nm, ex, d)
    endtask

    // Poll the flag word, bounded well past the bus timeout
    task automatic wait_bit(input [15:0] mask);
        v = 16'h0000;
        for (i = 0; i < 200 && (v & mask) == 16'h0000; i++)
            csr_r(2'h0, v);
        if ((v & mask) == 16'h0000)
        begin
            error_cnt++;
            $display("Error wait_bit exp %h got %h", mask, v);
            finish_test();
        end
    endtask

    task automatic pulse_evt(input int n);
        @(posedge core_clk);
        evt <= 5'h01 << n;
        @(posedge core_clk);
        evt <= 5'h00;
    endtask

    task automatic mem_w(input [1:0] idx, input [15:0] d);
        @(posedge core_clk);
        mem_we <= 1'b1;
        mem_idx <= idx;
        mem_wdata <= d;
        @(posedge core_clk);
        mem_we <= 1'b0;
    endtask

    initial
    begin
        {rst_b, csr_sel, csr_wr, mute, mem_we, want_fail} = 6'h00;
        {csr_idx, csr_be, mem_idx, delay, evt} = 15'h0000;
        {csr_wdata, mem_wdata, blk} = 50'h0;
        checked = 0;
        error_cnt = 0;
        seed_val = $urandom(32'h044FC53A);
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        chk_rd(2'h0, 16'h0880, "flags_reset");
        chk_rd(2'h2, 16'h0000, "addr_reset");
        csr_w(2'h0, 2'b10, 16'h0000); // Zero keeps the flag
        chk_rd(2'h0, 16'h0880, "zero_write");
        csr_w(2'h0, 2'b10, 16'h0800);
        chk_rd(2'h0, 16'h0000, "done_clear");
        // Every byte-enable pattern on an address register
        for (k = 0; k < 4; k++)
        begin
            v = 16'($urandom);
            e = 16'($urandom);
            csr_w(2'h2, 2'b11, v);
            csr_w(2'h2, 2'(k), e);
            chk_rd(2'h2, merge(v, e, 2'(k)), "byte_merge");
        end
        // Each event flag sets, interrupts, and clears by writing one
        csr_w(2'h0, 2'b01, 16'h0040);
        for (k = 0; k < 5; k++)
        begin
            pulse_evt(k);
            chk_rd(2'h0, flag_tab[k] | 16'h00C0, "evt");
            `CHK("irq", 1'b1, host_irq)
            csr_w(2'h0, 2'b10, flag_tab[k]);
            chk_rd(2'h0, 16'h0040, "evt_clear");
        end
        // Load address then fetch and run, pass and fail alternating
        for (k = 0; k < 4; k++)
        begin
            blk = {1'b0, 14'($urandom), 3'b000};
            delay <= 4'($urandom_range(5, 0));
            csr_w(2'h2, 2'b11, blk[15:0]);
            csr_w(2'h3, 2'b11, {14'h0000, blk[17:16]});
            csr_w(2'h0, 2'b01, 16'h0041);
            wait_bit(16'h0800);
            csr_w(2'h0, 2'b10, 16'h0800);
            for (i = 0; i < 4; i++)
            begin
                words[i] = 16'($urandom);
                mem_w(2'(i), words[i]);
            end
            want_fail = k[0];
            ex = want_fail ? 16'h40C2 : 16'h08C2;
            csr_w(2'h0, 2'b01, 16'h0042);
            wait_bit(ex & 16'hFF00);
            `CHK("code", words[0][7:0], cap_code)
            `CHK("args", {words[1], words[2], words[3]}, cap_args)
            chk_rd(2'h0, ex, "outcome");
            csr_r(2'h1, v);
            if (want_fail)
                `CHK("cause_fn", 1'b0, v[7])
            csr_w(2'h0, 2'b10, 16'hFF00);
        end
        // Bus timeout during the fetch
        mute <= 1'b1;
        csr_w(2'h0, 2'b01, 16'h0042);
        wait_bit(16'h4000);
        csr_r(2'h1, v);
        `CHK("cause_tmo", 1'b1, v[7])
        mute <= 1'b0;
        csr_w(2'h0, 2'b10, 16'hFF00);
        csr_w(2'h0, 2'b01, 16'h0047); // Unknown code completes
        wait_bit(16'h0800);
        chk_rd(2'h0, 16'h08C7, "unknown");
        csr_w(2'h0, 2'b11, 16'h0840); // No-op sets nothing
        repeat (4) @(posedge core_clk);
        chk_rd(2'h0, 16'h0040, "noop");
        pulse_evt(1);
        csr_w(2'h0, 2'b01, 16'h0060); // Soft reset
        repeat (3) @(posedge core_clk);
        chk_rd(2'h0, 16'h0880, "soft_rst");
        chk_rd(2'h2, 16'h0000, "soft_rst_addr");
        finish_test();
    end
endmodule
